// ===== include/adc_sel_pkg.sv
// Contract
// [R1] Result readable only after done flag
// [R2] Done flag and result update together
// [R3] Single-ended: unsigned code, 0x000..0x3FF
// [R4] Differential: two's complement, 0x200..0x1FF
// [R5] Differential saturates at both full scales
// [R6] Result bit 9 is differential sign
// [R7] Input select register, 8 bits, reset zero
// [R8] Reference select decode: ext, supply, reserved, internal
// [R9] Reference/channel changes wait for conversion end
// [R10] Software avoids internal references with external drive
// [R11] Left adjust re-presents stored result immediately
// [R12] Codes 0-7: single-ended inputs, no gain
// [R13] Codes 8-15: gain pairs, 10x or 200x
// [R14] Codes 16-29: 1x pairs against input 1/2
// [R15] Code 30 bandgap, code 31 ground
// [R16] Left/right adjust byte placement
package adc_sel_pkg;
  localparam int RES_W = 10;
  // Register word addresses (byte address = 4 * index)
  localparam logic [3:0] IDX_STATUS  = 4'h4;
  localparam logic [3:0] IDX_MASK    = 4'h5;
  localparam logic [3:0] IDX_CTRL    = 4'h6;
  localparam logic [3:0] IDX_INSEL   = 4'h7;
  localparam logic [3:0] IDX_RES_LO  = 4'h8;
  localparam logic [3:0] IDX_RES_HI  = 4'h9;
  localparam logic [3:0] IDX_ACTIVE  = 4'hA;
  localparam logic [7:0] INSEL_RESET = 8'h00;
  // Input select field layout
  localparam int REF_HI = 7;
  localparam int REF_LO = 6;
  localparam int LADJ_BIT = 5;
  localparam int CHAN_HI = 4;
  // Control / status bits
  localparam int CTRL_START = 0;
  localparam int STAT_DONE  = 0;
  localparam int STAT_BUSY  = 1;
  typedef enum logic [1:0] {
    REF_EXT_PIN  = 2'b00,
    REF_SUPPLY   = 2'b01,
    REF_RESERVED = 2'b10,
    REF_INTERNAL = 2'b11
  } ref_sel_t;
  typedef enum logic [1:0] {
    GAIN_NONE = 2'b00,
    GAIN_1X   = 2'b01,
    GAIN_10X  = 2'b10,
    GAIN_200X = 2'b11
  } gain_t;
  localparam logic [4:0] CODE_BANDGAP = 5'h1E;
  localparam logic [4:0] CODE_GROUND  = 5'h1F;
  localparam logic [9:0] SE_MAX   = 10'h3FF;
  localparam logic [9:0] DIFF_MAX = 10'h1FF;
  localparam logic [9:0] DIFF_MIN = 10'h200;
endpackage : adc_sel_pkg

// ===== hw/adc_result_format.sv
`timescale 1ns/1ps
// Places a stored 10-bit result into two bytes, left or right adjusted
module adc_result_format (
  // Stored result and presentation choice
  input  wire logic [9:0] result,
  input  wire logic       left_adjust,
  // Presented bytes
  output logic      [7:0] result_low_byte,
  output logic      [7:0] result_high_byte
);
  always_comb begin
    if (left_adjust) begin
      result_high_byte = result[9:2];                 // [R16]
      result_low_byte  = {result[1:0], 6'h00};        // [R16]
    end else begin
      result_high_byte = {6'h00, result[9:8]};        // [R16]
      result_low_byte  = result[7:0];                 // [R16]
    end
  end
endmodule : adc_result_format

// ===== hw/adc_result_and_input_select.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
// Converter control: input select register, result capture and formatting.
// The analog core reports a raw reading; this block latches settings per
// conversion, clamps and encodes the code, and presents it to software.
module adc_result_and_input_select (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Analog core
  output logic             conv_start,
  input  wire logic        conv_complete,
  input  wire logic signed [11:0] conv_raw,
  output logic      [1:0]  reference_select,
  output logic      [2:0]  pos_input,
  output logic      [2:0]  neg_input,
  output logic      [1:0]  gain_sel,
  output logic             single_ended,
  output logic             bandgap_sel,
  output logic             ground_sel,
  // Interrupt
  output logic             irq
);
  logic [7:0] insel_ff;        // software copy of input_select_register
  logic [7:0] applied_ff;      // reference/channel in effect
  logic       busy_ff;
  logic       start_ff;
  logic [9:0] result_ff;
  logic [1:0] status_ff;
  logic [1:0] mask_ff;
  logic       ack_ff;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic       access;
  logic       wr_hit;
  logic [3:0] idx;
  logic       diff_mode;
  logic [9:0] nxt_result;

  // Decoded selection of one channel/gain code
  function automatic logic [10:0] chan_decode(input logic [4:0] code);
    // Returns {single, pos[2:0], neg[2:0], gain[1:0], bandgap, ground}
    logic [2:0] p;
    logic [2:0] n;
    logic [1:0] g;
    logic       se;
    p  = 3'h0;
    n  = 3'h0;
    g  = adc_sel_pkg::GAIN_NONE;
    se = 1'b0;
    if (code[4:3] == 2'b00) begin
      se = 1'b1;                                       // [R12]
      p  = code[2:0];                                  // [R12]
    end else if (code[4:3] == 2'b01) begin
      p = {1'b0, code[2], code[0]};                    // [R13]
      n = {1'b0, code[2], 1'b0};                       // [R13]
      g = code[1] ? adc_sel_pkg::GAIN_200X : adc_sel_pkg::GAIN_10X; // [R13]
    end else if (code[4:3] == 2'b10) begin
      p = code[2:0];                                   // [R14]
      n = 3'h1;                                        // [R14]
      g = adc_sel_pkg::GAIN_1X;                        // [R14]
    end else if (code < adc_sel_pkg::CODE_BANDGAP) begin
      p = code[2:0];                                   // [R14]
      n = 3'h2;                                        // [R14]
      g = adc_sel_pkg::GAIN_1X;                        // [R14]
    end else begin
      se = 1'b1;                                       // [R15]
    end
    chan_decode = {se, p, n, g, code == adc_sel_pkg::CODE_BANDGAP,
                   code == adc_sel_pkg::CODE_GROUND};  // [R15]
  endfunction : chan_decode

  assign idx    = address[5:2];
  assign access = (read || write) && !ack_ff;
  // A write lands only at the edge where waitrequest is seen low
  assign wr_hit = write && ack_ff && byteenable[0];
  // One wait cycle per access keeps read data registered
  assign waitrequest = (read || write) && !ack_ff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= access;
    end
  end

  // Input select register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      insel_ff <= adc_sel_pkg::INSEL_RESET;            // [R7]
    end else if (wr_hit && idx == adc_sel_pkg::IDX_INSEL) begin
      insel_ff <= writedata[7:0];                      // [R7]
    end
  end

  // Settings are applied only while idle, so a write during a conversion
  // waits until the done event returns the block to idle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      applied_ff <= adc_sel_pkg::INSEL_RESET;
    end else if (!busy_ff) begin
      applied_ff <= insel_ff;                          // [R9]
    end
  end

  // Start pulse and busy tracking
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= wr_hit && idx == adc_sel_pkg::IDX_CTRL
                  && writedata[adc_sel_pkg::CTRL_START] && !busy_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
    end else if (start_ff) begin
      busy_ff <= 1'b1;
    end else if (conv_complete) begin
      busy_ff <= 1'b0;                                 // [R9]
    end
  end
  assign conv_start = start_ff;

  // Drive analog selection from the applied copy; start waits one cycle
  // so the copy taken at the start edge is what the core sees
  always_comb begin
    logic [10:0] d;
    d = chan_decode(applied_ff[adc_sel_pkg::CHAN_HI:0]);
    reference_select = applied_ff[adc_sel_pkg::REF_HI:adc_sel_pkg::REF_LO]; // [R8]
    single_ended = d[10];
    pos_input    = d[9:7];
    neg_input    = d[6:4];
    gain_sel     = d[3:2];
    bandgap_sel  = d[1];
    ground_sel   = d[0];
  end
  assign diff_mode = !single_ended;

  // Raw reading is signed steps; clamp to the code range of the mode
  always_comb begin
    if (!diff_mode) begin
      if (conv_raw < 12'sd0) begin
        nxt_result = 10'h000;                          // [R3]
      end else if (conv_raw > $signed({2'b00, adc_sel_pkg::SE_MAX})) begin
        nxt_result = adc_sel_pkg::SE_MAX;              // [R3]
      end else begin
        nxt_result = conv_raw[9:0];                    // [R3]
      end
    end else if (conv_raw > $signed({2'b00, adc_sel_pkg::DIFF_MAX})) begin
      nxt_result = adc_sel_pkg::DIFF_MAX;              // [R5]
    end else if (conv_raw < -$signed({2'b00, adc_sel_pkg::DIFF_MIN})) begin
      nxt_result = adc_sel_pkg::DIFF_MIN;              // [R5]
    end else begin
      // Two's complement keeps bit 9 as the sign
      nxt_result = conv_raw[9:0];                      // [R4] [R6]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      result_ff <= 10'h000;
    end else if (busy_ff && conv_complete) begin
      result_ff <= nxt_result;                         // [R1] [R2]
    end
  end

  // Status: done and spare busy-start event; set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_ff <= 2'b00;
    end else begin
      logic [1:0] clr;
      clr = (wr_hit && idx == adc_sel_pkg::IDX_STATUS) ? writedata[1:0] : 2'b00;
      status_ff[adc_sel_pkg::STAT_DONE] <= (busy_ff && conv_complete)  // [R2]
        || (status_ff[adc_sel_pkg::STAT_DONE] && !clr[adc_sel_pkg::STAT_DONE]);
      status_ff[adc_sel_pkg::STAT_BUSY] <= start_ff
        || (status_ff[adc_sel_pkg::STAT_BUSY] && !clr[adc_sel_pkg::STAT_BUSY]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mask_ff <= 2'b00;
    end else if (wr_hit && idx == adc_sel_pkg::IDX_MASK) begin
      mask_ff <= writedata[1:0];
    end
  end
  assign irq = |(status_ff & mask_ff);

  // Formatting follows the live left-adjust bit, not the applied copy
  adc_result_format u_fmt (
    .result           (result_ff),
    .left_adjust      (insel_ff[adc_sel_pkg::LADJ_BIT]),   // [R11]
    .result_low_byte  (res_lo),
    .result_high_byte (res_hi)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_ff) begin
      unique case (idx)
        adc_sel_pkg::IDX_STATUS: readdata <= {30'h0, status_ff};
        adc_sel_pkg::IDX_MASK:   readdata <= {30'h0, mask_ff};
        adc_sel_pkg::IDX_CTRL:   readdata <= {31'h0, busy_ff};
        adc_sel_pkg::IDX_INSEL:  readdata <= {24'h0, insel_ff};
        adc_sel_pkg::IDX_RES_LO: readdata <= {24'h0, res_lo};
        adc_sel_pkg::IDX_RES_HI: readdata <= {24'h0, res_hi};
        adc_sel_pkg::IDX_ACTIVE: readdata <= {24'h0, applied_ff};
        default:                 readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : adc_result_and_input_select

// ===== bench/adc_select_monitor.sv
`timescale 1ns/1ps
module adc_select_monitor (
  input wire logic clk_sys, reset_n, read, write, waitrequest, irq,
  input wire logic conv_start, conv_complete, single_ended, bandgap_sel, ground_sel,
  input wire logic        [5:0]  address,
  input wire logic        [31:0] writedata, readdata,
  input wire logic        [3:0]  byteenable,
  input wire logic signed [11:0] conv_raw,
  input wire logic        [1:0]  reference_select, gain_sel,
  input wire logic        [2:0]  pos_input, neg_input
);
  logic busy_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk_sys) begin
    if (!reset_n || conv_complete) busy_ff <= 1'b0;
    else if (conv_start) busy_ff <= 1'b1;
  end
  chk_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest held past first cycle");
  chk_start_cause: assert property (conv_start |-> $past(write && !waitrequest
      && byteenable[0] && address[5:2] == adc_sel_pkg::IDX_CTRL && writedata[0]))
    else $error("conversion start without control write");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  chk_hold_setting: assert property (busy_ff && !conv_complete |=>
      $stable({reference_select, pos_input, neg_input, gain_sel, single_ended}))
    else $error("settings changed during conversion");
  chk_diff_gain: assert property (!single_ended && !bandgap_sel && !ground_sel
      |-> gain_sel != adc_sel_pkg::GAIN_NONE)
    else $error("differential input without gain");
  chk_pair_neg: assert property (gain_sel[1] && !single_ended
      |-> neg_input == {1'b0, pos_input[1], 1'b0})
    else $error("gain pair negative input wrong");
  chk_unity_neg: assert property (gain_sel == adc_sel_pkg::GAIN_1X
      |-> neg_input inside {3'h1, 3'h2})
    else $error("unity pair negative input wrong");
  chk_special_sel: assert property (bandgap_sel |-> !ground_sel)
    else $error("bandgap and ground selected together");
  cover property (conv_complete && busy_ff);
  cover property (irq);
  cover property (bandgap_sel && reference_select == 2'h3);
endmodule : adc_select_monitor

// ===== bench/adc_core_model.sv
`timescale 1ns/1ps
// Analog core stand-in: answers a start after a set number of cycles
module adc_core_model (
  input  wire logic               clk_sys,
  input  wire logic               conv_start,
  input  wire logic signed [11:0] raw_value,
  input  wire logic        [3:0]  delay,
  output logic                    conv_complete = 1'b0,
  output logic signed [11:0]      conv_raw
);
  logic [3:0] left_ff = 4'h0;
  always_ff @(posedge clk_sys) begin
    conv_complete <= (left_ff == 4'h1);
    if (conv_start) left_ff <= delay;
    else if (left_ff != 4'h0) left_ff <= left_ff - 4'h1;
  end
  // Reading is valid only with the pulse; elsewhere the lines show junk
  assign conv_raw = conv_complete ? raw_value : ~raw_value;
endmodule : adc_core_model

// ===== bench/adc_result_and_input_select_bench.sv
`timescale 1ns/1ps
module adc_result_and_input_select_bench;
  logic clk_sys = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0;
  logic        [5:0]  address = 6'h00;
  logic        [31:0] writedata = 32'h0, readdata, rd;
  logic        [3:0]  byteenable = 4'hF, delay = 4'h3;
  logic waitrequest, conv_start, conv_complete, single_ended, bandgap_sel, ground_sel, irq;
  logic signed [11:0] conv_raw, raw_value = 12'h000;
  logic        [1:0]  reference_select, gain_sel, eg;
  logic        [2:0]  pos_input, neg_input, ep, en;
  logic        [4:0]  m;
  logic        [7:0]  sel_tab [5] = '{8'h03, 8'h10, 8'h10, 8'h10, 8'h03};
  logic signed [11:0] raw_tab [5] = '{12'h000, 12'h258, 12'hDA8, 12'hFFF, 12'h44C};
  logic        [9:0]  exp_tab [5] = '{10'h000, 10'h1FF, 10'h200, 10'h3FF, 10'h3FF};
  int miscompares = 0, comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  adc_result_and_input_select dut (.*);
  adc_core_model core (.*);
  task automatic report_and_stop();
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic access(input logic wr, input logic [3:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    read <= !wr; write <= wr; address <= {idx, 2'b00}; writedata <= {24'h0, d};
    // Look at waitrequest between edges so the edge that takes the request is known
    @(negedge clk_sys);
    while (waitrequest !== 1'b0 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 20) miscompares++;
    rd = readdata;
    @(posedge clk_sys);
    read <= 1'b0;
    write <= 1'b0;
  endtask : access
  task automatic wait_done();
    int k;
    k = 0;
    while (conv_complete !== 1'b1 && k < 40) begin @(posedge clk_sys); k++; end
    if (k == 40) miscompares++;
    repeat (2) @(posedge clk_sys);
  endtask : wait_done
  task automatic check_result(input logic [7:0] lo, input logic [7:0] hi);
    access(1'b0, adc_sel_pkg::IDX_RES_LO, 8'h00);
    check("result low", {24'h0, lo}, rd);
    access(1'b0, adc_sel_pkg::IDX_RES_HI, 8'h00);
    check("result high", {24'h0, hi}, rd);
  endtask : check_result
  initial begin
    #(3000 * 100);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    access(1'b0, adc_sel_pkg::IDX_INSEL, 8'h00);
    check("input select reset", 32'h0, rd);
    access(1'b0, 4'hF, 8'h00);
    check("unmapped", 32'h0, rd);
    for (int c = 0; c < 32; c++) begin
      m = c[4:0];
      access(1'b1, adc_sel_pkg::IDX_INSEL, {m[1:0], 1'b0, m});
      repeat (2) @(posedge clk_sys);
      eg = (m < 8 || m > 29) ? 2'h0 : (m < 16) ? {1'b1, m[1]} : 2'h1;
      ep = (m > 7 && m < 16) ? {1'b0, m[2], m[0]} : m[2:0];
      en = (m < 16) ? {1'b0, m[2], 1'b0} : (m < 24) ? 3'h1 : 3'h2;
      check("select", {m[1:0], eg, ep, en}, {reference_select, gain_sel, (m > 29) ? ep : pos_input, (m < 8 || m > 29) ? en : neg_input});
      check("kind", {m < 8 || m > 29, m == 30, m == 31}, {single_ended, bandgap_sel, ground_sel});
    end
    access(1'b1, adc_sel_pkg::IDX_INSEL, 8'hED);
    access(1'b1, adc_sel_pkg::IDX_MASK, 8'h01);
    raw_value <= 12'hE70;
    access(1'b1, adc_sel_pkg::IDX_CTRL, 8'h01);
    wait_done();
    check_result(8'h00, 8'h9C);
    check("irq set", 32'h1, {31'h0, irq});
    access(1'b1, adc_sel_pkg::IDX_STATUS, 8'h01);
    repeat (2) @(posedge clk_sys);
    check("irq cleared", 32'h0, {31'h0, irq});
    access(1'b1, adc_sel_pkg::IDX_INSEL, 8'hCD);
    check_result(8'h70, 8'h02);
    access(1'b1, adc_sel_pkg::IDX_MASK, 8'h00);
    for (int i = 0; i < 5; i++) begin
      access(1'b1, adc_sel_pkg::IDX_INSEL, sel_tab[i]);
      raw_value <= raw_tab[i];
      access(1'b1, adc_sel_pkg::IDX_CTRL, 8'h01);
      wait_done();
      check_result(exp_tab[i][7:0], {6'h0, exp_tab[i][9:8]});
    end
    check("irq masked", 32'h0, {31'h0, irq});
    access(1'b0, adc_sel_pkg::IDX_STATUS, 8'h00);
    check("done flag", 32'h1, {31'h0, rd[0]});
    access(1'b1, adc_sel_pkg::IDX_INSEL, 8'h00);
    delay <= 4'hF;
    raw_value <= 12'h2BC;
    access(1'b1, adc_sel_pkg::IDX_CTRL, 8'h01);
    access(1'b1, adc_sel_pkg::IDX_INSEL, 8'h17);
    check("held input", 32'h0, {29'h0, pos_input});
    access(1'b0, adc_sel_pkg::IDX_ACTIVE, 8'h00);
    check("applied setting", 32'h0, rd);
    check_result(8'hFF, 8'h03);
    wait_done();
    check("new input", 32'h7, {29'h0, pos_input});
    check_result(8'hBC, 8'h02);
    report_and_stop();
  end
endmodule : adc_result_and_input_select_bench
bind adc_result_and_input_select adc_select_monitor mon (.*);
